/* File: ctcr_regs.svh */
// register offsets, field positions, reset values and timing counts
// Notes on behaviour
// - timer control bit 7 set suppresses the status pin; resets to zero.
// - slow-down bit halves safety timer rate during input limiting or thermal loop.
// - safety timer enable gates all safety timers; default one, restored by reset or watchdog.
// - pre-charge timer is 2.5 hours when select is zero, 0.62 hours when one.
// - fast charge timer is 14.5 hours when select is zero, 28 hours when one.
// - auto discharge bit applies battery discharge during battery overvoltage fault.
// - forced battery discharge bit sinks battery current; cleared by reset or watchdog.
// - charge enable permits charging; default one, restored by reset or watchdog.
// - high impedance bit; cleared by reset, watchdog expiry or adapter plug-in.
// - forced mid node discharge bit; cleared by reset or watchdog expiry.
// - host writes kick bit; device restarts watchdog and clears the bit itself.
// - watchdog period 00 off, 01/10/11 give 50/100/200 s; resets to 01.
// - register reset command restores defaults, resets timers, reads zero afterwards.
// - thermal threshold bit selects 60 C at zero, 120 C at one; resets one.
// - frequency field 00/01/10 gives 1.5/1.35/1.65 MHz; code 11 reserved.
// - drive strength 00 weak, 01 normal, 11 strong (reset); code 10 reserved.
// - input overvoltage bit selects 6.3 V at zero, 18.5 V at one; resets one.
`ifndef CTCR_REGS_SVH
`define CTCR_REGS_SVH
////////////////////////////////////////////////////////////////////////////////
// offsets
`define CTCR_OFS_TIMER 8'h15
`define CTCR_OFS_CTRL1 8'h16
`define CTCR_OFS_CTRL2 8'h17
// reset values
`define CTCR_RST_TIMER 8'h0c
`define CTCR_RST_CTRL1 8'ha1
`define CTCR_RST_CTRL2 8'h4f
// writable bits, reserved bits read zero except control 2 bit 1, which reset sets to one and any write to control 2 clears
`define CTCR_WMASK_TIMER 8'h8f
`define CTCR_WMASK_CTRL1 8'hff
`define CTCR_WMASK_CTRL2 8'hfd
// fields restored on watchdog expiry
`define CTCR_WDMASK_TIMER 8'h04
`define CTCR_WDMASK_CTRL1 8'h78
////////////////////////////////////////////////////////////////////////////////
// field positions
`define CTCR_B_STAT_DIS 7
`define CTCR_B_HALF_RATE 3
`define CTCR_B_SAFETY_EN 2
`define CTCR_B_PRE_SEL 1
`define CTCR_B_FAST_SEL 0
`define CTCR_B_AUTO_DIS 7
`define CTCR_B_FORCE_BAT 6
`define CTCR_B_CHG_EN 5
`define CTCR_B_HIZ 4
`define CTCR_B_FORCE_MID 3
`define CTCR_B_KICK 2
`define CTCR_B_WD_HI 1
`define CTCR_B_WD_LO 0
`define CTCR_B_REG_RST 7
`define CTCR_B_THERMAL_REGULATION_THRESHOLD 6
`define CTCR_B_FREQ_HI 5
`define CTCR_B_FREQ_LO 4
`define CTCR_B_STRN_HI 3
`define CTCR_B_STRN_LO 2
`define CTCR_B_OVP 0
// reserved codes
`define CTCR_FREQ_RSVD 2'h3
`define CTCR_STRN_RSVD 2'h2
////////////////////////////////////////////////////////////////////////////////
// timing
`define CTCR_CLK_PERIOD_NS 4
`define CTCR_NS_PER_SEC 1000000000
`define CTCR_CYC_PER_SEC (`CTCR_NS_PER_SEC / `CTCR_CLK_PERIOD_NS)
`define CTCR_SEC_PER_CHR 36
`define CTCR_PRE_LONG_CHR 250
`define CTCR_PRE_SHORT_CHR 62
`define CTCR_FAST_SHORT_CHR 1450
`define CTCR_FAST_LONG_CHR 2800
`define CTCR_WD_CODE1_S 50
`define CTCR_WD_CODE2_S 100
`define CTCR_WD_CODE3_S 200
`endif

/* File: ctcr_pkg.sv */
// types shared by the charger timer and control register block
package ctcr_pkg;
  typedef enum logic [1:0] {
    CTCR_PH_IDLE,
    CTCR_PH_TRICKLE,
    CTCR_PH_PRECHARGE,
    CTCR_PH_FAST
  } ctcr_phase_t;

  typedef enum logic [1:0] {
    CTCR_TMR_IDLE,
    CTCR_TMR_RUN,
    CTCR_TMR_EXPIRED
  } ctcr_tmr_state_t;

  typedef struct packed {
    logic status_pin_disable;
    logic timer_half_rate_enable;
    logic safety_timers_enable;
    logic precharge_timer_select;
    logic fast_charge_timer_select;
    logic auto_battery_discharge_enable;
    logic forced_battery_discharge;
    logic charge_enable;
    logic high_impedance_mode_enable;
    logic forced_midnode_discharge;
    logic [1:0] watchdog_period;
    logic thermal_regulation_threshold;
    logic [1:0] converter_frequency_select;
    logic [1:0] gate_drive_strength_select;
    logic input_overvoltage_threshold;
  } ctcr_ctrl_t;
endpackage

/* File: ctcr_tick.sv */
// one-cycle tick every CYCLES clocks, restartable
module ctcr_tick #(
  parameter int CYCLES = 250000000
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clear,
  output logic o_tick
);
  localparam int W = $clog2(CYCLES);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  generate
    if (CYCLES < 2)
    begin : g_chk
      $error("ctcr_tick: CYCLES must be at least 2");
    end
  endgenerate

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // clear restarts the phase so a full period follows
  always_comb
  begin
    cnt_nxt = cnt_r + W'(1);
    tick_nxt = 1'b0;
    if (i_clear)
    begin
      cnt_nxt = '0;
    end
    else if (cnt_r == LAST)
    begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign o_tick = tick_r;
endmodule

/* File: ctcr_top.sv */
// charger timer and control registers with watchdog and safety timers
`include "ctcr_regs.svh"
module ctcr_top #(
  parameter int CYC_PER_SEC = `CTCR_CYC_PER_SEC,
  parameter int PRE_LONG_S = `CTCR_PRE_LONG_CHR * `CTCR_SEC_PER_CHR,
  parameter int PRE_SHORT_S = `CTCR_PRE_SHORT_CHR * `CTCR_SEC_PER_CHR,
  parameter int FAST_SHORT_S = `CTCR_FAST_SHORT_CHR * `CTCR_SEC_PER_CHR,
  parameter int FAST_LONG_S = `CTCR_FAST_LONG_CHR * `CTCR_SEC_PER_CHR,
  parameter int WD1_S = `CTCR_WD_CODE1_S,
  parameter int WD2_S = `CTCR_WD_CODE2_S,
  parameter int WD3_S = `CTCR_WD_CODE3_S
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire ctcr_pkg::ctcr_phase_t i_charge_phase,
  input wire logic i_input_limit_active,
  input wire logic i_thermal_reg_active,
  input wire logic i_battery_ovp_fault,
  input wire logic i_adapter_plug_in,
  output ctcr_pkg::ctcr_ctrl_t o_ctrl,
  output logic o_status_pin_enable,
  output logic o_battery_discharge,
  output logic o_safety_timer_expired,
  output logic o_watchdog_expired
);
  localparam int TW = 17;

  generate
    if (FAST_LONG_S >= (1 << TW) || PRE_LONG_S >= (1 << TW) ||
        PRE_SHORT_S < 1 || FAST_SHORT_S < 1 || WD3_S > 255 || WD1_S < 1)
    begin : g_chk
      $error("ctcr_top: timer durations out of range");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0] tmr_r;
  logic [7:0] tmr_nxt;
  logic [7:0] c1_r;
  logic [7:0] c1_nxt;
  logic [7:0] c2_r;
  logic [7:0] c2_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rvalid_r;
  logic rst_cmd;
  logic kick;
  logic wd_expire;
  logic wr_tmr;
  logic wr_c1;
  logic wr_c2;
  logic [7:0] wmerge2;

  assign wr_tmr = i_reg_wr && (i_reg_addr == `CTCR_OFS_TIMER);
  assign wr_c1 = i_reg_wr && (i_reg_addr == `CTCR_OFS_CTRL1);
  assign wr_c2 = i_reg_wr && (i_reg_addr == `CTCR_OFS_CTRL2);
  // the command bits stand for one cycle, then act and fall back
  assign rst_cmd = c2_r[`CTCR_B_REG_RST];
  assign kick = c1_r[`CTCR_B_KICK];

  // reserved codes are refused so the converter never sees them
  always_comb
  begin
    wmerge2 = i_reg_wdata & `CTCR_WMASK_CTRL2;
    if (wmerge2[`CTCR_B_FREQ_HI:`CTCR_B_FREQ_LO] == `CTCR_FREQ_RSVD)
    begin
      wmerge2[`CTCR_B_FREQ_HI:`CTCR_B_FREQ_LO] =
        c2_r[`CTCR_B_FREQ_HI:`CTCR_B_FREQ_LO];
    end
    if (wmerge2[`CTCR_B_STRN_HI:`CTCR_B_STRN_LO] == `CTCR_STRN_RSVD)
    begin
      wmerge2[`CTCR_B_STRN_HI:`CTCR_B_STRN_LO] =
        c2_r[`CTCR_B_STRN_HI:`CTCR_B_STRN_LO];
    end
  end

  // priority: register reset, then watchdog expiry, then host write
  always_comb
  begin
    tmr_nxt = tmr_r;
    c1_nxt = c1_r;
    c2_nxt = c2_r;
    c1_nxt[`CTCR_B_KICK] = 1'b0;
    c2_nxt[`CTCR_B_REG_RST] = 1'b0;
    if (wr_tmr)
    begin
      tmr_nxt = i_reg_wdata & `CTCR_WMASK_TIMER;
    end
    if (wr_c1)
    begin
      c1_nxt = i_reg_wdata & `CTCR_WMASK_CTRL1;
    end
    if (wr_c2)
    begin
      c2_nxt = wmerge2;
    end
    if (i_adapter_plug_in)
    begin
      c1_nxt[`CTCR_B_HIZ] = 1'b0;
    end
    if (wd_expire)
    begin
      tmr_nxt = (tmr_nxt & ~`CTCR_WDMASK_TIMER) |
                (`CTCR_RST_TIMER & `CTCR_WDMASK_TIMER);
      c1_nxt = (c1_nxt & ~`CTCR_WDMASK_CTRL1) |
               (`CTCR_RST_CTRL1 & `CTCR_WDMASK_CTRL1);
    end
    if (rst_cmd)
    begin
      tmr_nxt = `CTCR_RST_TIMER;
      c1_nxt = `CTCR_RST_CTRL1;
      c2_nxt = `CTCR_RST_CTRL2;
    end
  end

  // read data is registered; unmapped offsets read zero
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        `CTCR_OFS_TIMER: rdata_nxt = tmr_r;
        `CTCR_OFS_CTRL1: rdata_nxt = c1_r;
        `CTCR_OFS_CTRL2: rdata_nxt = c2_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      tmr_r <= `CTCR_RST_TIMER;
      c1_r <= `CTCR_RST_CTRL1;
      c2_r <= `CTCR_RST_CTRL2;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end
    else
    begin
      tmr_r <= tmr_nxt;
      c1_r <= c1_nxt;
      c2_r <= c2_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= i_reg_rd;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_reg_rvalid = rvalid_r;

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  logic wd_tick;
  logic [7:0] wd_cnt_r;
  logic [7:0] wd_cnt_nxt;
  logic [7:0] wd_limit;
  logic wd_flag_r;
  logic wd_flag_nxt;
  logic wd_restart;

  assign wd_restart = kick || rst_cmd || (wd_limit == 8'h00);

  ctcr_tick #(
    .CYCLES(CYC_PER_SEC)
  ) u_wd_tick (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_clear(wd_restart),
    .o_tick(wd_tick)
  );

  // period code to seconds, code zero disables
  always_comb
  begin
    case (c1_r[`CTCR_B_WD_HI:`CTCR_B_WD_LO])
      2'h1: wd_limit = 8'(WD1_S);
      2'h2: wd_limit = 8'(WD2_S);
      2'h3: wd_limit = 8'(WD3_S);
      default: wd_limit = 8'h00;
    endcase
  end

  assign wd_expire = !wd_restart && wd_tick &&
                     (wd_cnt_r >= wd_limit - 8'h01);

  // a kick in the same cycle outranks a fresh expiry
  always_comb
  begin
    wd_cnt_nxt = wd_cnt_r;
    wd_flag_nxt = wd_flag_r;
    if (wd_restart)
    begin
      wd_cnt_nxt = 8'h00;
    end
    else if (wd_expire)
    begin
      wd_cnt_nxt = 8'h00;
    end
    else if (wd_tick)
    begin
      wd_cnt_nxt = wd_cnt_r + 8'h01;
    end
    if (kick || rst_cmd)
    begin
      wd_flag_nxt = 1'b0;
    end
    if (wd_expire)
    begin
      wd_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      wd_cnt_r <= 8'h00;
      wd_flag_r <= 1'b0;
    end
    else
    begin
      wd_cnt_r <= wd_cnt_nxt;
      wd_flag_r <= wd_flag_nxt;
    end
  end

  assign o_watchdog_expired = wd_flag_r;

  ////////////////////////////////////////////////////////////////////////////
  // safety timer; trickle and pre-charge use the same pre-charge limit
  ctcr_pkg::ctcr_tmr_state_t st_r;
  ctcr_pkg::ctcr_tmr_state_t st_nxt;
  ctcr_pkg::ctcr_phase_t phase_r;
  logic [TW-1:0] st_cnt_r;
  logic [TW-1:0] st_cnt_nxt;
  logic [TW-1:0] st_limit;
  logic half_r;
  logic half_nxt;
  logic sec_tick;
  logic slow;
  logic advance;
  logic timing_phase;
  logic phase_chg;

  ctcr_tick #(
    .CYCLES(CYC_PER_SEC)
  ) u_st_tick (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_clear(rst_cmd),
    .o_tick(sec_tick)
  );

  always_comb
  begin
    if (i_charge_phase == ctcr_pkg::CTCR_PH_FAST)
    begin
      st_limit = tmr_r[`CTCR_B_FAST_SEL] ? TW'(FAST_LONG_S) :
                 TW'(FAST_SHORT_S);
    end
    else
    begin
      st_limit = tmr_r[`CTCR_B_PRE_SEL] ? TW'(PRE_SHORT_S) :
                 TW'(PRE_LONG_S);
    end
  end

  assign slow = tmr_r[`CTCR_B_HALF_RATE] &&
                (i_input_limit_active || i_thermal_reg_active);
  assign advance = sec_tick && (!slow || half_r);
  assign timing_phase = (i_charge_phase != ctcr_pkg::CTCR_PH_IDLE);
  assign phase_chg = (i_charge_phase != phase_r);

  // every phase change starts a fresh budget
  always_comb
  begin
    st_nxt = st_r;
    st_cnt_nxt = st_cnt_r;
    half_nxt = half_r;
    if (sec_tick && slow)
    begin
      half_nxt = !half_r;
    end
    case (st_r)
      ctcr_pkg::CTCR_TMR_IDLE:
      begin
        st_cnt_nxt = '0;
        half_nxt = 1'b0;
        if (timing_phase)
        begin
          st_nxt = ctcr_pkg::CTCR_TMR_RUN;
        end
      end
      ctcr_pkg::CTCR_TMR_RUN:
      begin
        if (advance)
        begin
          if (st_cnt_r >= st_limit - TW'(1))
          begin
            st_nxt = ctcr_pkg::CTCR_TMR_EXPIRED;
          end
          st_cnt_nxt = st_cnt_r + TW'(1);
        end
      end
      ctcr_pkg::CTCR_TMR_EXPIRED: st_nxt = ctcr_pkg::CTCR_TMR_EXPIRED;
      default: st_nxt = ctcr_pkg::CTCR_TMR_IDLE;
    endcase
    if (!tmr_r[`CTCR_B_SAFETY_EN] || rst_cmd || phase_chg || !timing_phase)
    begin
      st_nxt = ctcr_pkg::CTCR_TMR_IDLE;
      st_cnt_nxt = '0;
      half_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      st_r <= ctcr_pkg::CTCR_TMR_IDLE;
      st_cnt_r <= '0;
      half_r <= 1'b0;
      phase_r <= ctcr_pkg::CTCR_PH_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
      st_cnt_r <= st_cnt_nxt;
      half_r <= half_nxt;
      phase_r <= i_charge_phase;
    end
  end

  assign o_safety_timer_expired = (st_r == ctcr_pkg::CTCR_TMR_EXPIRED);

  ////////////////////////////////////////////////////////////////////////////
  // control outputs straight from the register bits
  assign o_ctrl.status_pin_disable = tmr_r[`CTCR_B_STAT_DIS];
  assign o_ctrl.timer_half_rate_enable = tmr_r[`CTCR_B_HALF_RATE];
  assign o_ctrl.safety_timers_enable = tmr_r[`CTCR_B_SAFETY_EN];
  assign o_ctrl.precharge_timer_select = tmr_r[`CTCR_B_PRE_SEL];
  assign o_ctrl.fast_charge_timer_select = tmr_r[`CTCR_B_FAST_SEL];
  assign o_ctrl.auto_battery_discharge_enable = c1_r[`CTCR_B_AUTO_DIS];
  assign o_ctrl.forced_battery_discharge = c1_r[`CTCR_B_FORCE_BAT];
  assign o_ctrl.charge_enable = c1_r[`CTCR_B_CHG_EN];
  assign o_ctrl.high_impedance_mode_enable = c1_r[`CTCR_B_HIZ];
  assign o_ctrl.forced_midnode_discharge = c1_r[`CTCR_B_FORCE_MID];
  assign o_ctrl.watchdog_period = c1_r[`CTCR_B_WD_HI:`CTCR_B_WD_LO];
  assign o_ctrl.thermal_regulation_threshold = c2_r[`CTCR_B_THERMAL_REGULATION_THRESHOLD];
  assign o_ctrl.converter_frequency_select =
    c2_r[`CTCR_B_FREQ_HI:`CTCR_B_FREQ_LO];
  assign o_ctrl.gate_drive_strength_select =
    c2_r[`CTCR_B_STRN_HI:`CTCR_B_STRN_LO];
  assign o_ctrl.input_overvoltage_threshold = c2_r[`CTCR_B_OVP];

  assign o_status_pin_enable = !tmr_r[`CTCR_B_STAT_DIS];
  // combinational so a fault reaches the sink without delay
  assign o_battery_discharge = c1_r[`CTCR_B_FORCE_BAT] ||
    (c1_r[`CTCR_B_AUTO_DIS] && i_battery_ovp_fault);
endmodule

/* File: ctcr_top_sva.sv */
// concurrent checks on the charger timer and control register ports
module ctcr_top_sva (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire ctcr_pkg::ctcr_phase_t i_charge_phase,
  input wire logic i_input_limit_active,
  input wire logic i_thermal_reg_active,
  input wire logic i_battery_ovp_fault,
  input wire logic i_adapter_plug_in,
  input wire ctcr_pkg::ctcr_ctrl_t o_ctrl,
  input wire logic o_status_pin_enable,
  input wire logic o_battery_discharge,
  input wire logic o_safety_timer_expired,
  input wire logic o_watchdog_expired
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  // all fields at default, in struct order
  localparam logic [17:0] DEF = 18'h19467;
  ////////////////////////////////////////
  // command steps
  sequence s_rst_cmd;
    i_reg_wr && i_reg_addr == 8'h17 && i_reg_wdata[7];
  endsequence
  sequence s_kick;
    i_reg_wr && i_reg_addr == 8'h16 && i_reg_wdata[2];
  endsequence
  property p_wr_stat;
    logic d;
    (i_reg_wr && i_reg_addr == 8'h15, d = i_reg_wdata[7]) |=>
      o_ctrl.status_pin_disable == d;
  endproperty
  ////////////////////////////////////////
  AST_POR: assert property ($rose(i_reset_n) |-> o_ctrl == DEF)
    else $error("fields not at default after reset");
  AST_REG_RESET: assert property (s_rst_cmd |=> ##1 o_ctrl == DEF
    && !o_watchdog_expired && !o_safety_timer_expired)
    else $error("register reset command did not restore defaults");
  AST_STAT_WR: assert property (p_wr_stat)
    else $error("status disable bit not written");
  AST_STAT_PIN: assert property (
    o_status_pin_enable == !o_ctrl.status_pin_disable)
    else $error("status pin enable wrong");
  AST_DISCHARGE: assert property (o_battery_discharge ==
    (o_ctrl.forced_battery_discharge ||
    (o_ctrl.auto_battery_discharge_enable && i_battery_ovp_fault)))
    else $error("battery discharge wrong");
  AST_PLUG: assert property (
    i_adapter_plug_in |=> !o_ctrl.high_impedance_mode_enable)
    else $error("plug in did not clear high impedance");
  AST_KICK: assert property (s_kick |=> ##1 !o_watchdog_expired)
    else $error("kick did not clear watchdog flag");
  AST_WD_EXPIRY: assert property ($rose(o_watchdog_expired) |->
    o_ctrl.safety_timers_enable && o_ctrl.charge_enable &&
    !o_ctrl.forced_battery_discharge &&
    !o_ctrl.high_impedance_mode_enable &&
    !o_ctrl.forced_midnode_discharge)
    else $error("watchdog expiry left fields unrestored");
  AST_IDLE: assert property (
    (i_charge_phase == ctcr_pkg::CTCR_PH_IDLE) [*3] |-> !o_safety_timer_expired)
    else $error("safety timer expired while idle");
  AST_UNMAPPED: assert property (i_reg_rd && i_reg_addr == 8'h20 |=>
    o_reg_rvalid && o_reg_rdata == 8'h00)
    else $error("unmapped read not answered with zero");
endmodule

bind ctcr_top ctcr_top_sva u_ctcr_top_sva (.i_clk, .i_reset_n, .i_reg_wr,
  .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid,
  .i_charge_phase, .i_input_limit_active, .i_thermal_reg_active,
  .i_battery_ovp_fault, .i_adapter_plug_in, .o_ctrl, .o_status_pin_enable,
  .o_battery_discharge, .o_safety_timer_expired, .o_watchdog_expired);

/* File: ctcr_host.sv */
// host model issuing register strobes toward the charger block
module ctcr_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus from time zero
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  ////////////////////////////////////////
  // one-cycle write strobe, a gap edge before the next
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask
  // bounded wait, so a dead answer cannot hang the run
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
    output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge i_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'b0;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(posedge i_clk);
      if (i_rvalid === 1'b1)
      begin
        ok = 1'b1;
        d = i_rdata;
      end
    end
  endtask
endmodule

/* File: ctcr_top_bench.sv */
// self-checking bench for the charger timer and control registers
module ctcr_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_reset_n, wr, rd, rvalid, lim, thr, ovp, plug;
  logic stat_en, bat_dis, tmr_exp, wd_exp;
  logic [7:0] addr, wdata, rdata;
  ctcr_pkg::ctcr_phase_t phase;
  ctcr_pkg::ctcr_ctrl_t ctrl;
  int err_total, n_compared, n, wd_cyc;
  // short seconds keep the run small; watchdog periods stay as built
  ctcr_top #(.CYC_PER_SEC(4), .PRE_LONG_S(5), .PRE_SHORT_S(3),
    .FAST_SHORT_S(6), .FAST_LONG_S(9))
    u_ctcr_top (.i_clk, .i_reset_n, .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_charge_phase(phase),
    .i_input_limit_active(lim), .i_thermal_reg_active(thr),
    .i_battery_ovp_fault(ovp), .i_adapter_plug_in(plug), .o_ctrl(ctrl),
    .o_status_pin_enable(stat_en), .o_battery_discharge(bat_dis),
    .o_safety_timer_expired(tmr_exp), .o_watchdog_expired(wd_exp));
  ctcr_host u_host (.i_clk, .i_rdata(rdata), .i_rvalid(rvalid), .o_wr(wr),
    .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  // 250 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  ////////////////////////////////////////
  task final_report;
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_host.rd(a, d, ok);
    chk("rvalid", 8'h01, 8'(ok));
    if (ok !== 1'b1)
      final_report;
    chk("rdata", exp, d);
  endtask
  // cycles from phase entry to expiry, within a tolerance of tol cycles
  task run_tmr(input logic [7:0] r15, input ctcr_pkg::ctcr_phase_t ph,
    input logic l, input logic t, input int cyc, input int tol);
    @(posedge i_clk);
    phase <= ctcr_pkg::CTCR_PH_IDLE;
    lim <= l;
    thr <= t;
    u_host.wr(8'h15, r15);
    @(posedge i_clk);
    phase <= ph;
    n = 0;
    while (tmr_exp !== 1'b1 && n < 400)
    begin
      @(posedge i_clk);
      n++;
    end
    chk("tmr_cycles", 8'h01, 8'(n >= cyc - tol && n <= cyc + tol));
    if (n >= 400)
      final_report;
  endtask
  // bounded wait for the watchdog flag, n holds the cycles waited
  task wait_wd;
    n = 0;
    while (wd_exp !== 1'b1 && n < 1000)
    begin
      @(posedge i_clk);
      n++;
    end
    chk("wd_expired", 8'h01, 8'(wd_exp));
    if (n >= 1000)
      final_report;
  endtask
  ////////////////////////////////////////
  // main sequence
  initial
  begin
    i_reset_n = 1'b0;
    phase = ctcr_pkg::CTCR_PH_IDLE;
    {lim, thr, ovp, plug} = 4'h0;
    err_total = 0;
    n_compared = 0;
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rdchk(8'h15, 8'h0c);
    rdchk(8'h16, 8'ha1);
    rdchk(8'h17, 8'h4f);
    rdchk(8'h20, 8'h00);
    chk("stat_en", 8'h01, 8'(stat_en));
    u_host.wr(8'h16, 8'ha0);
    u_host.wr(8'h15, 8'hff);
    rdchk(8'h15, 8'h8f);
    chk("stat_en", 8'h00, 8'(stat_en));
    // reserved codes refused, other fields taken
    u_host.wr(8'h17, 8'h7f);
    rdchk(8'h17, 8'h4d);
    u_host.wr(8'h17, 8'h29);
    rdchk(8'h17, 8'h2d);
    u_host.wr(8'h17, 8'h14);
    rdchk(8'h17, 8'h14);
    chk("ctrl_freq", 8'h01, 8'(ctrl.converter_frequency_select));
    // discharge paths
    @(posedge i_clk);
    ovp <= 1'b1;
    @(posedge i_clk);
    chk("bat_dis", 8'h01, 8'(bat_dis));
    u_host.wr(8'h16, 8'h20);
    @(posedge i_clk);
    chk("bat_dis", 8'h00, 8'(bat_dis));
    ovp <= 1'b0;
    u_host.wr(8'h16, 8'h60);
    @(posedge i_clk);
    chk("bat_dis", 8'h01, 8'(bat_dis));
    u_host.wr(8'h16, 8'h30);
    rdchk(8'h16, 8'h30);
    @(posedge i_clk);
    plug <= 1'b1;
    @(posedge i_clk);
    plug <= 1'b0;
    rdchk(8'h16, 8'h20);
    u_host.wr(8'h17, 8'h80);
    rdchk(8'h17, 8'h4f);
    rdchk(8'h15, 8'h0c);
    u_host.wr(8'h16, 8'ha0);
    // kick with forced bits set, then let the watchdog run out
    u_host.wr(8'h16, 8'h4d);
    u_host.wr(8'h15, 8'h08);
    rdchk(8'h16, 8'h49);
    wait_wd;
    rdchk(8'h15, 8'h0c);
    rdchk(8'h16, 8'h21);
    // each period code, timed from the kick
    for (int c = 1; c < 4; c++)
    begin
      u_host.wr(8'h16, 8'ha4 | 8'(c));
      // the old flag only falls at the second edge after the write
      repeat (2) @(posedge i_clk);
      wd_cyc = 4 * (c == 3 ? 200 : 50 * c);
      wait_wd;
      chk("wd_cycles", 8'h01, 8'(n >= wd_cyc - 3 && n <= wd_cyc + 3));
    end
    u_host.wr(8'h16, 8'ha4);
    repeat (2) @(posedge i_clk);
    chk("wd_expired", 8'h00, 8'(wd_exp));
    run_tmr(8'h04, ctcr_pkg::CTCR_PH_FAST, 1'b1, 1'b0, 24, 6);
    run_tmr(8'h05, ctcr_pkg::CTCR_PH_FAST, 1'b0, 1'b0, 36, 6);
    run_tmr(8'h0c, ctcr_pkg::CTCR_PH_FAST, 1'b1, 1'b0, 48, 10);
    run_tmr(8'h0c, ctcr_pkg::CTCR_PH_FAST, 1'b0, 1'b1, 48, 10);
    run_tmr(8'h06, ctcr_pkg::CTCR_PH_PRECHARGE, 1'b0, 1'b0, 12, 6);
    run_tmr(8'h04, ctcr_pkg::CTCR_PH_TRICKLE, 1'b0, 1'b0, 20, 6);
    // timers disabled: no expiry however long
    @(posedge i_clk);
    phase <= ctcr_pkg::CTCR_PH_IDLE;
    u_host.wr(8'h15, 8'h00);
    @(posedge i_clk);
    phase <= ctcr_pkg::CTCR_PH_FAST;
    repeat (60) @(posedge i_clk);
    chk("tmr_expired", 8'h00, 8'(tmr_exp));
    final_report;
  end
endmodule
